// ==== dcr_pkg.sv ====
// Package for the synthesizer control function register decode.
// Assumes one 40 MHz clock and a synchronous active-high reset.
package dcr_pkg;

  // ----------------------------------------------------------------
  // Register layout
  // ----------------------------------------------------------------
  localparam int CFR_WIDTH = 32;
  localparam logic [31:0] CFR_RESET = 32'h0000_0000;
  localparam int FD_CUR_HI = 31;
  localparam int FD_CUR_LO = 30;
  localparam int FCL_CUR_HI = 29;
  localparam int FCL_CUR_LO = 27;
  localparam int WCL_CUR_HI = 26;
  localparam int WCL_CUR_LO = 24;
  localparam int FACC_AUTOCLR_BIT = 23;
  localparam int PACC_AUTOCLR_BIT = 22;
  localparam int RAMP_AUTORELOAD_BIT = 21;
  localparam int FACC_HOLDCLR_BIT = 20;
  localparam int PACC_HOLDCLR_BIT = 19;
  localparam int FASTLOCK_EN_BIT = 17;
  localparam int FASTLOCK_NOFTW_BIT = 16;
  localparam int SWEEP_EN_BIT = 15;
  localparam int SINE_SEL_BIT = 14;
  localparam int PUMP_OFFSET_BIT = 13;
  localparam int DIVN_HI = 12;
  localparam int DIVN_LO = 11;

  // ----------------------------------------------------------------
  // Datapath widths
  // ----------------------------------------------------------------
  localparam int ACC_WIDTH = 32;
  localparam int RAMP_WIDTH = 16;
  localparam int BYTE_COUNT = 4;

  // Charge pump operating modes chosen by the pump control logic.
  typedef enum logic [2:0] {
    PUMP_FREQ_DETECT = 3'h1,
    PUMP_FINAL_LOOP = 3'h2,
    PUMP_WIDE_LOOP = 3'h4
  } dcr_pump_mode_e;

endpackage

// ==== dcr_accum.sv ====
// Clearable accumulator used for both the frequency and phase paths.
// Assumes the add enable and clear terms are synchronous to clk.
`timescale 1ns/1ps
module dcr_accum
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic addEn,
  input wire logic clear,
  input wire logic [ACC_WIDTH-1:0] addend,
  output logic [ACC_WIDTH-1:0] sum
);

  logic [ACC_WIDTH-1:0] sum_q;
  logic [ACC_WIDTH-1:0] sum_d;

  // Clear loads zeros and wins over the add.
  always_comb begin
    sum_d = sum_q;
    if (clear) begin
      sum_d = '0;
    end else if (addEn) begin
      sum_d = sum_q + addend;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      sum_q <= '0;
    end else begin
      sum_q <= sum_d;
    end
  end

  assign sum = sum_q;

endmodule

// ==== dcr_ramp_timer.sv ====
// Ramp rate down-counter that paces frequency accumulator steps.
// Assumes the strobe and policy input are synchronous to clk.
`timescale 1ns/1ps
module dcr_ramp_timer
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic autoReload,
  input wire logic updateStrobe,
  input wire logic [RAMP_WIDTH-1:0] rampRate,
  output logic tick
);

  logic [RAMP_WIDTH-1:0] count_q;
  logic [RAMP_WIDTH-1:0] count_d;
  logic timeout;

  assign timeout = (count_q == '0);
  assign tick = enable && timeout;

  // Reload either on the strobe or on timeout, never both policies.
  always_comb begin
    count_d = count_q;
    if (autoReload ? timeout : updateStrobe) begin
      count_d = rampRate;
    end else if (!timeout) begin
      count_d = count_q - RAMP_WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ==== dcr_control_decode.sv ====
// Control function register with decode of bits 31 down to 11.
// Assumes an I/O port writes whole bytes and a one-cycle update strobe.
`timescale 1ns/1ps
module dcr_control_decode
  import dcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic cfgWrEn,
  input wire logic [1:0] cfgByteSel,
  input wire logic [7:0] cfgWrData,
  input wire logic freq_update_strobe,
  input wire logic [2:0] pumpMode,
  input wire logic [ACC_WIDTH-1:0] freq_tuning_word,
  input wire logic [ACC_WIDTH-1:0] sweep_delta_freq_word,
  input wire logic [RAMP_WIDTH-1:0] sweep_ramp_rate_word,
  output logic [31:0] control_function_reg,
  output logic [2:0] pumpScale,
  output logic [3:0] wideLoopScale,
  output logic [2:0] finalLoopScale,
  output logic [2:0] freqDetectScale,
  output logic pumpOffsetEn,
  output logic fastLockEn,
  output logic fastLockUseFtw,
  output logic sweepEn,
  output logic sineSel,
  output logic [2:0] divRatio,
  output logic [ACC_WIDTH-1:0] freqAccum,
  output logic [ACC_WIDTH-1:0] phaseAccum
);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic [31:0] cfr_q;
  logic [31:0] cfr_d;

  // Byte select 0 addresses bits 31:24, matching serial MSB-first order.
  always_comb begin
    cfr_d = cfr_q;
    if (cfgWrEn) begin
      case (cfgByteSel)
        2'h0: cfr_d[31:24] = cfgWrData;
        2'h1: cfr_d[23:16] = cfgWrData;
        2'h2: cfr_d[15:8] = cfgWrData;
        2'h3: cfr_d[7:0] = cfgWrData;
        default: cfr_d = cfr_q;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cfr_q <= CFR_RESET;
    end else begin
      cfr_q <= cfr_d;
    end
  end

  // ----------------------------------------------------------------
  // Field decode
  // ----------------------------------------------------------------
  logic [1:0] fdCode;
  logic [2:0] fclCode;
  logic [1:0] divCode;
  logic [2:0] fdScale_d;
  logic [2:0] fdScale_q;
  logic [2:0] fclScale_d;
  logic [2:0] fclScale_q;
  logic [3:0] wclScale_d;
  logic [3:0] wclScale_q;
  logic [2:0] pumpScale_d;
  logic [2:0] pumpScale_q;
  logic [2:0] divRatio_d;
  logic [2:0] divRatio_q;
  logic fastLockEn_d;
  logic fastLockEn_q;
  logic fastLockUseFtw_d;
  logic fastLockUseFtw_q;
  logic sweepEn_d;
  logic sweepEn_q;
  logic sineSel_d;
  logic sineSel_q;
  logic pumpOffsetEn_d;
  logic pumpOffsetEn_q;

  assign fdCode = cfr_d[FD_CUR_HI:FD_CUR_LO];
  assign fclCode = cfr_d[FCL_CUR_HI:FCL_CUR_LO];
  assign divCode = cfr_d[DIVN_HI:DIVN_LO];

  // Decode from the next register value so outputs track it registered.
  always_comb begin
    case (fdCode)
      2'h0: fdScale_d = 3'h0;
      2'h1: fdScale_d = 3'h2;
      2'h2: fdScale_d = 3'h3;
      default: fdScale_d = 3'h4;
    endcase
    fclScale_d = fclCode[2] ? (3'({1'b0, fclCode[1:0]}) + 3'h1) : 3'h0;
    wclScale_d = {cfr_d[WCL_CUR_HI:WCL_CUR_LO], 1'b0};
    case (divCode)
      2'h0: divRatio_d = 3'h1;
      2'h1: divRatio_d = 3'h2;
      default: divRatio_d = 3'h4;
    endcase
    // The wide loop scale needs four bits, so it only shows on its own output.
    case (pumpMode)
      PUMP_FREQ_DETECT: pumpScale_d = fdScale_d;
      PUMP_FINAL_LOOP: pumpScale_d = fclScale_d;
      default: pumpScale_d = 3'h0;
    endcase
    fastLockEn_d = cfr_d[FASTLOCK_EN_BIT];
    fastLockUseFtw_d = !cfr_d[FASTLOCK_NOFTW_BIT];
    sweepEn_d = cfr_d[SWEEP_EN_BIT];
    sineSel_d = cfr_d[SINE_SEL_BIT];
    pumpOffsetEn_d = cfr_d[PUMP_OFFSET_BIT];
  end

  // Decode flip-flops; bit 18 reaches none of them.
  always_ff @(posedge clk) begin
    if (reset) begin
      fdScale_q <= 3'h0;
      fclScale_q <= 3'h0;
      wclScale_q <= 4'h0;
      pumpScale_q <= 3'h0;
      divRatio_q <= 3'h1;
      fastLockEn_q <= 1'b0;
      fastLockUseFtw_q <= 1'b1;
      sweepEn_q <= 1'b0;
      sineSel_q <= 1'b0;
      pumpOffsetEn_q <= 1'b0;
    end else begin
      fdScale_q <= fdScale_d;
      fclScale_q <= fclScale_d;
      wclScale_q <= wclScale_d;
      pumpScale_q <= pumpScale_d;
      divRatio_q <= divRatio_d;
      fastLockEn_q <= fastLockEn_d;
      fastLockUseFtw_q <= fastLockUseFtw_d;
      sweepEn_q <= sweepEn_d;
      sineSel_q <= sineSel_d;
      pumpOffsetEn_q <= pumpOffsetEn_d;
    end
  end

  // Outputs come straight from the register and the decode flip-flops.
  assign control_function_reg = cfr_q;
  assign freqDetectScale = fdScale_q;
  assign finalLoopScale = fclScale_q;
  assign wideLoopScale = wclScale_q;
  assign pumpScale = pumpScale_q;
  assign divRatio = divRatio_q;
  assign fastLockEn = fastLockEn_q;
  assign fastLockUseFtw = fastLockUseFtw_q;
  assign sweepEn = sweepEn_q;
  assign sineSel = sineSel_q;
  assign pumpOffsetEn = pumpOffsetEn_q;

  // ----------------------------------------------------------------
  // Accumulators and ramp timer
  // ----------------------------------------------------------------
  logic rampTick;
  logic freqClr;
  logic phaseClr;
  logic [ACC_WIDTH-1:0] freqSum;
  logic [ACC_WIDTH-1:0] phaseSum;
  logic [ACC_WIDTH-1:0] phaseStep;

  // One-shot clear on strobe, or held clear while the hold bit is set.
  assign freqClr = (cfr_q[FACC_AUTOCLR_BIT] && freq_update_strobe)
    || cfr_q[FACC_HOLDCLR_BIT];
  assign phaseClr = (cfr_q[PACC_AUTOCLR_BIT] && freq_update_strobe)
    || cfr_q[PACC_HOLDCLR_BIT];
  assign phaseStep = cfr_q[SWEEP_EN_BIT] ? freq_tuning_word + freqSum : freq_tuning_word;

  dcr_ramp_timer u_ramp (
    .clk(clk),
    .reset(reset),
    .enable(cfr_q[SWEEP_EN_BIT]),
    .autoReload(cfr_q[RAMP_AUTORELOAD_BIT]),
    .updateStrobe(freq_update_strobe),
    .rampRate(sweep_ramp_rate_word),
    .tick(rampTick)
  );

  // Frequency accumulator steps by the delta word on each ramp tick.
  dcr_accum u_freq (
    .clk(clk),
    .reset(reset),
    .addEn(rampTick),
    .clear(freqClr),
    .addend(sweep_delta_freq_word),
    .sum(freqSum)
  );

  // Phase accumulator adds the effective tuning word every cycle.
  dcr_accum u_phase (
    .clk(clk),
    .reset(reset),
    .addEn(1'b1),
    .clear(phaseClr),
    .addend(phaseStep),
    .sum(phaseSum)
  );

  assign freqAccum = freqSum;
  assign phaseAccum = phaseSum;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_strobeAuto(int b);
    freq_update_strobe && cfr_q[b];
  endsequence

  sequence s_byteWrite(logic [1:0] sel);
    cfgWrEn && cfgByteSel == sel;
  endsequence

  property p_fd_scale;
    @(posedge clk) disable iff (reset)
      cfgWrEn && cfgByteSel == 2'h0 && cfgWrData[7:6] == 2'h1 |=> freqDetectScale == 3'h2;
  endproperty
  a_fd_scale: assert property (p_fd_scale) else $error("freq detect scale wrong");

  property p_fd_mode;
    @(posedge clk) disable iff (reset)
      pumpMode == PUMP_FREQ_DETECT |=> pumpScale == freqDetectScale;
  endproperty
  a_fd_mode: assert property (p_fd_mode) else $error("pump scale not freq detect");

  property p_fcl;
    @(posedge clk) disable iff (reset)
      cfgWrEn && cfgByteSel == 2'h0 && cfgWrData[5:3] == 3'h7 |=> finalLoopScale == 3'h4;
  endproperty
  a_fcl: assert property (p_fcl) else $error("final loop scale wrong");

  property p_wcl;
    @(posedge clk) disable iff (reset)
      cfgWrEn && cfgByteSel == 2'h0 |=> wideLoopScale == {$past(cfgWrData[2:0]), 1'b0};
  endproperty
  a_wcl: assert property (p_wcl) else $error("wide loop scale wrong");

  property p_fclr;
    @(posedge clk) disable iff (reset)
      s_strobeAuto(FACC_AUTOCLR_BIT) |=> freqAccum == '0;
  endproperty
  a_fclr: assert property (p_fclr) else $error("freq accumulator not cleared");

  property p_pclr;
    @(posedge clk) disable iff (reset)
      s_strobeAuto(PACC_AUTOCLR_BIT) |=> phaseAccum == '0;
  endproperty
  a_pclr: assert property (p_pclr) else $error("phase accumulator not cleared");

  property p_fhold;
    @(posedge clk) disable iff (reset)
      cfr_q[FACC_HOLDCLR_BIT] [*2] |-> freqAccum == '0;
  endproperty
  a_fhold: assert property (p_fhold) else $error("freq accumulator not held");

  property p_phold;
    @(posedge clk) disable iff (reset)
      cfr_q[PACC_HOLDCLR_BIT] [*2] |-> phaseAccum == '0;
  endproperty
  a_phold: assert property (p_phold) else $error("phase accumulator not held");

  property p_padd;
    @(posedge clk) disable iff (reset)
      !phaseClr && !cfr_q[SWEEP_EN_BIT]
      |=> phaseAccum == ACC_WIDTH'($past(phaseAccum) + $past(freq_tuning_word));
  endproperty
  a_padd: assert property (p_padd) else $error("phase accumulator not adding");

  property p_div;
    @(posedge clk) disable iff (reset)
      cfgWrEn && cfgByteSel == 2'h2 && cfgWrData[4] |=> divRatio == 3'h4;
  endproperty
  a_div: assert property (p_div) else $error("divider ratio wrong");

  property p_sweep;
    @(posedge clk) disable iff (reset)
      1'b1 |=> sweepEn == cfr_q[SWEEP_EN_BIT] && sineSel == cfr_q[SINE_SEL_BIT];
  endproperty
  a_sweep: assert property (p_sweep) else $error("mode bits not tracking");

  property p_msb_byte;
    @(posedge clk) disable iff (reset)
      s_byteWrite(2'h0) |=> control_function_reg[31:24] == $past(cfgWrData);
  endproperty
  a_msb_byte: assert property (p_msb_byte) else $error("byte zero not in top bits");

  property p_fcl_off;
    @(posedge clk) disable iff (reset)
      s_byteWrite(2'h0) ##0 !cfgWrData[5] |=> finalLoopScale == 3'h0;
  endproperty
  a_fcl_off: assert property (p_fcl_off) else $error("final loop scale not zero");

  property p_fadd;
    @(posedge clk) disable iff (reset)
      rampTick && !freqClr
      |=> freqAccum == ACC_WIDTH'($past(freqAccum) + $past(sweep_delta_freq_word));
  endproperty
  a_fadd: assert property (p_fadd) else $error("freq accumulator not adding");

  property p_ramp_strobe;
    @(posedge clk) disable iff (reset)
      freq_update_strobe && !cfr_q[RAMP_AUTORELOAD_BIT] && sweep_ramp_rate_word != '0
      |=> !rampTick;
  endproperty
  a_ramp_strobe: assert property (p_ramp_strobe) else $error("timer not reloaded");

  property p_ramp_auto;
    @(posedge clk) disable iff (reset)
      rampTick && cfr_q[RAMP_AUTORELOAD_BIT] && sweep_ramp_rate_word != '0 |=> !rampTick;
  endproperty
  a_ramp_auto: assert property (p_ramp_auto) else $error("timer not reloaded");

  property p_fastlock;
    @(posedge clk) disable iff (reset)
      1'b1 |=> fastLockEn == cfr_q[FASTLOCK_EN_BIT]
        && fastLockUseFtw == !cfr_q[FASTLOCK_NOFTW_BIT];
  endproperty
  a_fastlock: assert property (p_fastlock) else $error("fast lock bits wrong");

  property p_reset_defaults;
    @(posedge clk)
      reset |=> control_function_reg == CFR_RESET && divRatio == 3'h1 && fastLockUseFtw
        && pumpScale == 3'h0 && freqAccum == '0 && phaseAccum == '0;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("reset values wrong");

endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the control function register decode.
// Assumes the design files and dcr_pkg are compiled before this file.
`timescale 1ns/1ps
module tb_top;
  import dcr_pkg::*;

  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic clk, reset, cfgWrEn, freq_update_strobe;
  logic [1:0] cfgByteSel;
  logic [7:0] cfgWrData;
  logic [2:0] pumpMode, pumpScale, finalLoopScale, freqDetectScale, divRatio;
  logic [3:0] wideLoopScale;
  logic [ACC_WIDTH-1:0] freq_tuning_word, sweep_delta_freq_word, freqAccum, phaseAccum;
  logic [RAMP_WIDTH-1:0] sweep_ramp_rate_word;
  logic [31:0] control_function_reg, snap;
  logic pumpOffsetEn, fastLockEn, fastLockUseFtw, sweepEn, sineSel;
  int failures, cmp_count, cnt;

  dcr_control_decode dcr_control_decode_inst (
    .clk(clk), .reset(reset), .cfgWrEn(cfgWrEn), .cfgByteSel(cfgByteSel),
    .cfgWrData(cfgWrData), .freq_update_strobe(freq_update_strobe),
    .pumpMode(pumpMode), .freq_tuning_word(freq_tuning_word),
    .sweep_delta_freq_word(sweep_delta_freq_word),
    .sweep_ramp_rate_word(sweep_ramp_rate_word), .control_function_reg(control_function_reg),
    .pumpScale(pumpScale), .wideLoopScale(wideLoopScale), .finalLoopScale(finalLoopScale),
    .freqDetectScale(freqDetectScale), .pumpOffsetEn(pumpOffsetEn), .fastLockEn(fastLockEn),
    .fastLockUseFtw(fastLockUseFtw), .sweepEn(sweepEn), .sineSel(sineSel),
    .divRatio(divRatio), .freqAccum(freqAccum), .phaseAccum(phaseAccum));

  // ------------------------------------------------------------------
  // Clock, tasks and watchdog
  // ------------------------------------------------------------------
  // A 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compares one value and counts it.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Writes one byte of the register with a one-cycle strobe.
  task automatic wr_byte(input logic [1:0] sel, input logic [7:0] data);
    @(negedge clk);
    cfgWrEn = 1'b1;
    cfgByteSel = sel;
    cfgWrData = data;
    @(negedge clk);
    cfgWrEn = 1'b0;
  endtask

  // Holds reset for three cycles, then checks the register and decode reset values, not the accumulators.
  task automatic do_reset();
    reset = 1'b1;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset = 1'b0;
    check(control_function_reg, CFR_RESET);
    check({pumpScale, wideLoopScale, finalLoopScale, freqDetectScale}, 32'h0);
    check({divRatio, fastLockUseFtw, fastLockEn, sweepEn, sineSel, pumpOffsetEn}, 32'h30);
  endtask

  // Pulses the update strobe and expects one zero cycle on the accumulator.
  task automatic strobe_zero(input bit usePhase, input logic [31:0] step);
    @(negedge clk);
    freq_update_strobe = 1'b1;
    @(negedge clk);
    freq_update_strobe = 1'b0;
    check(usePhase ? phaseAccum : freqAccum, 32'h0);
    @(negedge clk);
    check(usePhase ? phaseAccum : freqAccum, step);
  endtask

  // Cuts a hang short.
  initial begin
    #(25 * 5000);
    failures++;
    test_done();
  end

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  // Drives every input from time zero, then runs the scenarios in order.
  initial begin
    failures = 0;
    cmp_count = 0;
    {cfgWrEn, freq_update_strobe, cfgByteSel, cfgWrData} = '0;
    pumpMode = 3'h1;
    freq_tuning_word = 32'h0000_0005;
    sweep_delta_freq_word = 32'h0000_0003;
    sweep_ramp_rate_word = 16'h0000;
    do_reset();
    // Every code of each current field and of the divider.
    for (int i = 0; i < 8; i++) begin
      logic [2:0] c;
      c = i[2:0];
      wr_byte(2'h0, {c[1:0], c, c});
      check(freqDetectScale, (c[1:0] == 2'h0) ? 32'h0 : c[1:0] + 32'h1);
      check(pumpScale, (c[1:0] == 2'h0) ? 32'h0 : c[1:0] + 32'h1);
      check(finalLoopScale, c[2] ? c[1:0] + 32'h1 : 32'h0);
      check(wideLoopScale, 32'(c) * 2);
      wr_byte(2'h2, {c, c[1:0], 3'h0});
      check({sweepEn, sineSel, pumpOffsetEn}, c);
      check(divRatio, c[1] ? 32'h4 : (c[0] ? 32'h2 : 32'h1));
    end
    // The pump scale follows the operating mode.
    pumpMode = 3'h2;
    @(negedge clk);
    check(pumpScale, 32'h4);
    pumpMode = 3'h4;
    @(negedge clk);
    check(pumpScale, 32'h0);
    // Single flags of the second byte, bit 18 included.
    for (int j = 0; j < 8; j++) begin
      wr_byte(2'h1, 8'h01 << j);
      check(fastLockEn, (j == 1));
      check(fastLockUseFtw, (j != 0));
      check(control_function_reg[23:16], 8'h01 << j);
    end
    // Byte order of the whole word, then a second reset in mid-run.
    wr_byte(2'h3, 8'h5A);
    wr_byte(2'h2, 8'hE9);
    wr_byte(2'h1, 8'h00);
    wr_byte(2'h0, 8'h9B);
    check(control_function_reg, 32'h9B00_E95A);
    do_reset();
    // Phase accumulator with sweep off.
    snap = phaseAccum;
    @(negedge clk);
    check(phaseAccum - snap, 32'h5);
    wr_byte(2'h1, 8'h08);
    repeat (2) @(negedge clk);
    check(phaseAccum, 32'h0);
    repeat (3) @(negedge clk);
    check(phaseAccum, 32'h0);
    wr_byte(2'h1, 8'h40);
    strobe_zero(1'b1, 32'h5);
    // Frequency accumulator in sweep mode with a zero ramp rate.
    wr_byte(2'h1, 8'h00);
    wr_byte(2'h2, 8'h80);
    snap = freqAccum;
    @(negedge clk);
    check(freqAccum - snap, 32'h3);
    wr_byte(2'h1, 8'h80);
    strobe_zero(1'b0, 32'h3);
    wr_byte(2'h1, 8'h10);
    repeat (5) @(negedge clk);
    check(freqAccum, 32'h0);
    // Reload on strobe only: the timer then holds the sweep for a while.
    sweep_ramp_rate_word = 16'h001E;
    wr_byte(2'h1, 8'h80);
    strobe_zero(1'b0, 32'h0);
    repeat (29) @(negedge clk);
    check(freqAccum, 32'h0);
    @(negedge clk);
    check(freqAccum, 32'h3);
    // Reload on timeout: steps keep coming and the strobe is ignored.
    sweep_ramp_rate_word = 16'h0004;
    wr_byte(2'h1, 8'h20);
    repeat (12) @(negedge clk);
    cnt = 0;
    for (int k = 0; k < 60; k++) begin
      snap = freqAccum;
      freq_update_strobe = (k == 30);
      @(negedge clk);
      if (freqAccum !== snap) cnt++;
    end
    check(cnt, 32'hC);
    test_done();
  end
endmodule
